// [src/watchdog_reset_delay_timer.sv]
// Watchdog timer and reset delay timer with an AXI4-Lite register slave.
// Assumes core instruction strobes on aclk; pin and fuse levels are asynchronous.
//
// How it works
// - Internal, RC or external-clock modes: delay is 18 ms after power-on, 10 us after later resets.
// - Crystal or resonator modes: delay is 18 ms after power-on and after every later reset.
// - With no prescaler assigned the watchdog expires after a nominal 18 ms.
// - Software assigns a prescaler of 1:1 up to 1:128 through the control register, stretching the timeout.
// - The clear-watchdog instruction zeroes the counter, and the prescaler when it is assigned.
// - The sleep instruction zeroes the counter and the assigned prescaler so a full period runs.
// - Expiry in normal running causes a full device reset unless cleared first.
// - Expiry while asleep causes a wake-up reset.
// - A watchdog reset clears the active-low timeout flag.
// - With the enable fuse at 0 the watchdog never causes a reset.
// - After power-up the reset latch is set and the delay counts only while master clear is high.
// - A wake from sleep by the watchdog also runs the reset delay before the core resumes.
`timescale 1ns/1ps
module watchdog_reset_delay_timer
  import wdt_pkg::*;
#(
  parameter int DRT_LONG = DRT_LONG_CYC,
  parameter int WDT_BASE = WDT_BASE_CYC
) (
  // Clock and power-on reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Core side
  input  wire logic              clear_watchdog_instr,
  input  wire logic              sleep_instr,
  output logic                   core_reset,
  output logic                   wake_reset,
  output logic                   timeout_flag_n,
  output logic                   irq,
  // Pin and configuration fuses
  input  wire logic              master_clear_pin,
  input  wire logic              watchdog_enable_fuse,
  input  wire logic [2:0]        osc_mode,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Last prescaler count for ratio 1:2^sel
  function automatic logic [PRE_W-1:0] pre_last(input logic [SEL_W-1:0] sel);
    pre_last = PRE_W'((9'h001 << sel) - 9'h001);
  endfunction

  function automatic logic is_crystal(input logic [2:0] m);
    is_crystal = (m == high_speed_crystal_mode) || (m == standard_crystal_mode) ||
                 (m == low_power_crystal_mode);
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic       master_clear_pin_s;
  logic       fuse_s;
  logic [2:0] mode_s;

  // Two stages; only the second stage feeds logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end else begin
      sync1_reg <= {osc_mode, watchdog_enable_fuse, master_clear_pin};
      sync2_reg <= sync1_reg;
    end
  end
  assign master_clear_pin_s = sync2_reg[0];
  assign fuse_s = sync2_reg[1];
  assign mode_s = sync2_reg[4:2];

  // ----------------------------------------------------------------
  // Timers and reset sequencer
  // ----------------------------------------------------------------
  state_t           state_reg, state_next;
  logic [CNT_W-1:0] drt_reg, drt_next;
  logic [CNT_W-1:0] base_reg, base_next;
  logic [PRE_W-1:0] pre_reg, pre_next;
  logic             por_reg, por_next;
  logic             rst_reg, rst_next;
  logic             to_n_reg, to_n_next;
  logic             wake_reg, wake_next;
  logic [3:0]       ctrl_reg;
  logic [CNT_W-1:0] drt_last;
  logic             wdt_on;
  logic             base_wrap;
  logic             wdt_expire;
  logic             drt_done;
  logic             assigned;

  assign assigned = ctrl_reg[CTRL_ASG_BIT];
  // Long delay on power-on or with a slow-starting crystal
  assign drt_last = (por_reg || is_crystal(mode_s)) ? CNT_W'(DRT_LONG - 1)
                                                    : CNT_W'(DRT_SHORT_CYC - 1);
  assign wdt_on    = fuse_s && (state_reg == ST_RUN || state_reg == ST_SLEEP);
  assign base_wrap = base_reg == CNT_W'(WDT_BASE - 1);
  // A clear in the same cycle beats expiry
  assign wdt_expire = wdt_on && base_wrap && !clear_watchdog_instr &&
                      (!assigned || pre_reg == pre_last(ctrl_reg[3:1]));
  assign drt_done  = state_reg == ST_COUNT && master_clear_pin_s && drt_reg == drt_last;

  // Next state of sequencer, delay and watchdog counters
  always_comb begin
    state_next = state_reg;
    drt_next   = drt_reg;
    base_next  = base_reg;
    pre_next   = pre_reg;
    por_next   = por_reg;
    to_n_next  = to_n_reg;
    wake_next  = 1'b0;
    if (wdt_on) begin
      base_next = base_wrap ? '0 : base_reg + 1'b1;
      if (base_wrap && assigned) begin
        pre_next = (pre_reg == pre_last(ctrl_reg[3:1])) ? '0 : pre_reg + 1'b1;
      end
    end
    case (state_reg)
      ST_HOLD: begin
        drt_next  = '0;
        base_next = '0;
        pre_next  = '0;
        if (master_clear_pin_s) begin
          state_next = ST_COUNT;
        end
      end
      ST_COUNT: begin
        drt_next = drt_reg + 1'b1;
        if (!master_clear_pin_s) begin
          state_next = ST_HOLD;
        end else if (drt_done) begin
          state_next = ST_RUN;
          por_next   = 1'b0;
        end
      end
      ST_RUN: begin
        if (!master_clear_pin_s) begin
          state_next = ST_HOLD;
        end else if (wdt_expire) begin
          state_next = ST_HOLD;
          to_n_next  = 1'b0;
        end else if (sleep_instr) begin
          state_next = ST_SLEEP;
          base_next  = '0;
          if (assigned) begin
            pre_next = '0;
          end
        end else if (clear_watchdog_instr) begin
          base_next = '0;
          to_n_next = 1'b1;
          if (assigned) begin
            pre_next = '0;
          end
        end
      end
      ST_SLEEP: begin
        if (!master_clear_pin_s) begin
          state_next = ST_HOLD;
        end else if (wdt_expire) begin
          state_next = ST_HOLD;
          to_n_next  = 1'b0;
          wake_next  = 1'b1;
        end
      end
      default: state_next = ST_HOLD;
    endcase
    rst_next = !(state_next == ST_RUN || state_next == ST_SLEEP);
  end

  // Sequencer registers; aresetn acts as the power-on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_HOLD;
      drt_reg   <= '0;
      base_reg  <= '0;
      pre_reg   <= '0;
      por_reg   <= 1'b1;
      rst_reg   <= 1'b1;
      to_n_reg  <= 1'b1;
      wake_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      drt_reg   <= drt_next;
      base_reg  <= base_next;
      pre_reg   <= pre_next;
      por_reg   <= por_next;
      rst_reg   <= rst_next;
      to_n_reg  <= to_n_next;
      wake_reg  <= wake_next;
    end
  end
  assign core_reset     = rst_reg;
  assign timeout_flag_n = to_n_reg;
  assign wake_reset     = wake_reg;

  // ----------------------------------------------------------------
  // AXI4-Lite slave and registers
  // ----------------------------------------------------------------
  logic [3:0]      ctrl_next;
  logic [EV_W-1:0] ev_reg, ev_next, mask_reg, mask_next;
  logic            aw_reg, aw_next, ar_reg, ar_next;
  logic            bv_reg, bv_next, rv_reg, rv_next, irq_reg, irq_next;
  logic [1:0]      br_reg, br_next, rr_reg, rr_next;
  logic [31:0]     rd_reg, rd_next;
  logic            wr_fire, rd_fire;
  logic [EV_W-1:0] ev_set;

  // Write taken once both address and data are offered
  assign wr_fire = aw_reg && awvalid && wvalid;
  assign rd_fire = ar_reg && arvalid;
  assign ev_set  = {drt_done, wake_next, wdt_expire && state_reg == ST_RUN};

  // Bus and register next values; event set wins over read-clear
  always_comb begin
    aw_next   = awvalid && wvalid && !aw_reg && !bv_reg;
    ar_next   = arvalid && !ar_reg && !rv_reg;
    bv_next   = bv_reg && !bready;
    br_next   = br_reg;
    rv_next   = rv_reg && !rready;
    rr_next   = rr_reg;
    rd_next   = rd_reg;
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    ev_next   = ev_reg;
    if (wr_fire) begin
      bv_next = 1'b1;
      br_next = RESP_OKAY;
      if (awaddr == CTRL_OFF) begin
        if (wstrb[0]) ctrl_next = wdata[3:0];
      end else if (awaddr == MASK_OFF) begin
        if (wstrb[0]) mask_next = wdata[EV_W-1:0];
      end else if (awaddr != STAT_OFF) begin
        br_next = RESP_SLVERR;
      end
    end
    if (rd_fire) begin
      rv_next = 1'b1;
      rr_next = RESP_OKAY;
      rd_next = 32'h0000_0000;
      case (araddr)
        CTRL_OFF: rd_next[3:0] = ctrl_reg;
        MASK_OFF: rd_next[EV_W-1:0] = mask_reg;
        STAT_OFF: begin
          rd_next[EV_W-1:0]  = ev_reg;
          rd_next[ST_TO_BIT]  = to_n_reg;
          rd_next[ST_RST_BIT] = rst_reg;
          rd_next[ST_SLP_BIT] = state_reg == ST_SLEEP;
          ev_next = '0;
        end
        default: rr_next = RESP_SLVERR;
      endcase
    end
    ev_next  = ev_next | ev_set;
    irq_next = |(ev_next & mask_next);
  end

  // Bus and register flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_reg   <= 1'b0;
      ar_reg   <= 1'b0;
      bv_reg   <= 1'b0;
      rv_reg   <= 1'b0;
      br_reg   <= RESP_OKAY;
      rr_reg   <= RESP_OKAY;
      rd_reg   <= 32'h0000_0000;
      ctrl_reg <= CTRL_RST;
      mask_reg <= MASK_RST;
      ev_reg   <= '0;
      irq_reg  <= 1'b0;
    end else begin
      aw_reg   <= aw_next;
      ar_reg   <= ar_next;
      bv_reg   <= bv_next;
      rv_reg   <= rv_next;
      br_reg   <= br_next;
      rr_reg   <= rr_next;
      rd_reg   <= rd_next;
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
      ev_reg   <= ev_next;
      irq_reg  <= irq_next;
    end
  end
  assign awready = aw_reg;
  assign wready  = aw_reg;
  assign bvalid  = bv_reg;
  assign bresp   = br_reg;
  assign arready = ar_reg;
  assign rvalid  = rv_reg;
  assign rresp   = rr_reg;
  assign rdata   = rd_reg;
  assign irq     = irq_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_drt_short;
    drt_done && !por_reg && !is_crystal(mode_s) |-> drt_reg == CNT_W'(DRT_SHORT_CYC - 1);
  endproperty
  a_drt_short: assert property (p_drt_short) else $error("short delay length wrong");

  property p_drt_long;
    drt_done && (por_reg || is_crystal(mode_s)) |-> drt_reg == CNT_W'(DRT_LONG - 1);
  endproperty
  a_drt_long: assert property (p_drt_long) else $error("long delay length wrong");

  property p_wdt_base;
    wdt_expire && !assigned |-> base_reg == CNT_W'(WDT_BASE - 1);
  endproperty
  a_wdt_base: assert property (p_wdt_base) else $error("watchdog period wrong");

  property p_wdt_pre;
    wdt_expire && assigned |-> pre_reg == pre_last(ctrl_reg[3:1]);
  endproperty
  a_wdt_pre: assert property (p_wdt_pre) else $error("prescaled expiry early");

  property p_clear;
    state_reg == ST_RUN && master_clear_pin_s && clear_watchdog_instr && !sleep_instr
      |=> base_reg == '0 && (!$past(assigned) || pre_reg == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not zero counter");

  property p_sleep;
    state_reg == ST_RUN && master_clear_pin_s && sleep_instr && !wdt_expire
      |=> state_reg == ST_SLEEP && base_reg == '0 ##1 base_reg == CNT_W'(1);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry wrong");

  property p_run_expire;
    state_reg == ST_RUN && master_clear_pin_s && wdt_expire |=> state_reg == ST_HOLD && core_reset ##1 core_reset;
  endproperty
  a_run_expire: assert property (p_run_expire) else $error("no reset on expiry");

  property p_sleep_expire;
    state_reg == ST_SLEEP && master_clear_pin_s && wdt_expire |=> wake_reset && core_reset ##1 state_reg == ST_COUNT [*2];
  endproperty
  a_sleep_expire: assert property (p_sleep_expire) else $error("no wake reset");

  property p_to_flag;
    wdt_expire && master_clear_pin_s |=> !timeout_flag_n;
  endproperty
  a_to_flag: assert property (p_to_flag) else $error("timeout flag not cleared");

  property p_fuse_off;
    !fuse_s && state_reg == ST_RUN && master_clear_pin_s |=> !core_reset;
  endproperty
  a_fuse_off: assert property (p_fuse_off) else $error("disabled watchdog counted");

  property p_wait_master_clear_pin;
    state_reg == ST_HOLD && !master_clear_pin_s |=> state_reg == ST_HOLD && drt_reg == '0;
  endproperty
  a_wait_master_clear_pin: assert property (p_wait_master_clear_pin) else $error("delay ran without master clear");

  property p_hold_core;
    state_reg == ST_COUNT |-> core_reset;
  endproperty
  a_hold_core: assert property (p_hold_core) else $error("core freed during delay");

  c_run_expire: cover property (state_reg == ST_RUN && wdt_expire);
  c_sleep_wake: cover property (state_reg == ST_SLEEP && wdt_expire);
  c_drt_done:   cover property (drt_done && !por_reg);
  c_irq:        cover property ($rose(irq));

endmodule // watchdog_reset_delay_timer

// [src/wdt_pkg.sv]
// Constants, field layouts and types of the watchdog and reset delay timer.
// Assumes a single 100 MHz system clock; all times are derived from it.
package wdt_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 100_000_000;
  localparam int DRT_LONG_MS   = 18;
  localparam int DRT_SHORT_US  = 10;
  localparam int WDT_NOM_MS    = 18;
  localparam int DRT_LONG_CYC  = DRT_LONG_MS * (CLK_HZ / 1000);
  localparam int DRT_SHORT_CYC = DRT_SHORT_US * (CLK_HZ / 1_000_000);
  localparam int WDT_BASE_CYC  = WDT_NOM_MS * (CLK_HZ / 1000);
  localparam int CNT_W         = 21;
  localparam int PRE_W         = 8;
  localparam int SEL_W         = 3;
  localparam int EV_W          = 3;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam int         ADDR_W       = 4;
  localparam logic [3:0] CTRL_OFF     = 4'h0;
  localparam logic [3:0] STAT_OFF     = 4'h4;
  localparam logic [3:0] MASK_OFF     = 4'h8;
  localparam int         CTRL_ASG_BIT = 0;
  localparam int         CTRL_SEL_LSB = 1;
  localparam int         EV_WDT_RST   = 0;
  localparam int         EV_WAKE      = 1;
  localparam int         EV_DRT_DONE  = 2;
  localparam int         ST_TO_BIT    = 4;
  localparam int         ST_RST_BIT   = 5;
  localparam int         ST_SLP_BIT   = 6;
  localparam logic [3:0] CTRL_RST     = 4'h0;
  localparam logic [2:0] MASK_RST     = 3'h0;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    internal_osc_mode       = 3'h0,
    external_rc_mode        = 3'h1,
    high_speed_crystal_mode = 3'h2,
    standard_crystal_mode   = 3'h3,
    low_power_crystal_mode  = 3'h4,
    external_clock_mode     = 3'h5
  } osc_mode_t;

  typedef enum logic [1:0] {
    ST_HOLD  = 2'b00,
    ST_COUNT = 2'b01,
    ST_RUN   = 2'b11,
    ST_SLEEP = 2'b10
  } state_t;
endpackage

// [tb/core_model.sv]
// Behavioural processor core issuing clear-watchdog and sleep instruction pulses.
// Assumes the block's aclk; the bench sets the keep-alive period and asks for sleep.
`timescale 1ns/1ps
module core_model (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Bench control
  input  wire logic [7:0] keep_period,
  input  wire logic       sleep_req,
  // Block side
  input  wire logic       core_reset,
  output logic            clear_watchdog_instr = 1'b0,
  output logic            sleep_instr = 1'b0
);
  logic [7:0] cnt_reg    = 8'h00;
  logic       asleep_reg = 1'b0;

  // ----------------------------------------------------------------
  // Instruction issue
  // ----------------------------------------------------------------
  // A core in reset or asleep executes nothing, so it cannot rescue itself
  always @(posedge aclk) begin
    clear_watchdog_instr <= 1'b0;
    sleep_instr          <= 1'b0;
    if (!aresetn || core_reset) begin
      cnt_reg    <= 8'h00;
      asleep_reg <= 1'b0;
    end else if (!asleep_reg) begin
      if (sleep_req) begin
        sleep_instr <= 1'b1;
        asleep_reg  <= 1'b1;
      end else if (keep_period != 8'h00 && cnt_reg >= keep_period - 8'h01) begin
        clear_watchdog_instr <= 1'b1;
        cnt_reg              <= 8'h00;
      end else begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end
endmodule // core_model

// [tb/test_watchdog_reset_delay_timer.sv]
// Self-checking bench of the watchdog and reset delay timer.
// Assumes short counts in simulation: power-on delay 50, watchdog base 20 cycles.
`timescale 1ns/1ps
module test_watchdog_reset_delay_timer;
  import wdt_pkg::*;
  localparam int DL    = 50;
  localparam int WB    = 20;
  localparam int SHORT = 1000;

  logic        aclk, aresetn, master_clear_pin, watchdog_enable_fuse, sleep_req;
  logic        clear_watchdog_instr, sleep_instr, core_reset, wake_reset, timeout_flag_n, irq;
  logic [2:0]  osc_mode;
  logic [7:0]  keep_period, lfsr;
  logic [3:0]  awaddr, araddr, wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd, ctrl;
  logic [1:0]  bresp, rresp, rs;
  int          fails, cmp_count, n, r;

  watchdog_reset_delay_timer #(.DRT_LONG(DL), .WDT_BASE(WB)) dut (.aclk, .aresetn, .clear_watchdog_instr,
    .sleep_instr, .core_reset, .wake_reset, .timeout_flag_n, .irq, .master_clear_pin, .watchdog_enable_fuse,
    .osc_mode, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  core_model u_core (.aclk, .aresetn, .keep_period, .sleep_req, .core_reset, .clear_watchdog_instr, .sleep_instr);

  // ----------------------------------------------------------------
  // Expectations and helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr_step(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Crystal modes need the long delay even after later resets
  function automatic int exp_drt(input int m);
    return (m >= 2 && m <= 4) ? DL : SHORT;
  endfunction
  function automatic int exp_wdt(input logic [31:0] c);
    return c[0] ? (WB << c[3:1]) : WB;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task span(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      fails++;
      $display("unexpected at %0t: span %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask
  // Each channel released at the edge where its own ready is seen
  task axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  // Counts cycles until core reset shows the wanted level, capped
  task wait_rst(input logic v, input int lim, output int cnt);
    cnt = 0;
    while (core_reset !== v && cnt < lim) begin
      @(posedge aclk);
      cnt++;
    end
  endtask
  task give_verdict;
    if (fails == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Whole run needs about 21k cycles; allow more than double
  initial begin
    #700_000;
    fails++;
    give_verdict;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    aresetn = 1'b0; master_clear_pin = 1'b0; watchdog_enable_fuse = 1'b1; osc_mode = 3'd0;
    sleep_req = 1'b0; keep_period = 8'd0; awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0; wstrb = 4'hF;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    fails = 0; cmp_count = 0; lfsr = 8'd41;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // Pin still low, so the delay must not have started
    repeat (100) @(posedge aclk);
    chk(32'(core_reset), 32'h1);
    axi_rd(CTRL_OFF, rd, rs); chk(rd, 32'h0);
    axi_rd(4'hC, rd, rs); chk({rd[29:0], rs}, {30'h0, RESP_SLVERR});
    axi_wr(MASK_OFF, 32'h7, rs); chk(32'(rs), 32'(RESP_OKAY));
    axi_wr(STAT_OFF, 32'h0, rs); axi_rd(MASK_OFF, rd, rs); chk(rd, 32'h7);
    lfsr = lfsr_step(lfsr);
    keep_period <= 8'd5 + 8'(lfsr % 10);
    master_clear_pin <= 1'b1;
    wait_rst(1'b0, 5000, n); span(n, DL, DL + 6);
    repeat (3) @(posedge aclk); chk(32'(irq), 32'h1);
    axi_rd(STAT_OFF, rd, rs); chk(rd & 32'h37, 32'h14);
    repeat (2) @(posedge aclk); chk(32'(irq), 32'h0);
    // Regular clears hold the watchdog off, also across a prescaler boundary; then the fuse at 0 holds it off with no clears
    wait_rst(1'b1, 300, n); span(n, 300, 300);
    axi_wr(CTRL_OFF, 32'h3, rs); keep_period <= 8'd30;
    wait_rst(1'b1, 300, n); span(n, 300, 300);
    watchdog_enable_fuse <= 1'b0;
    repeat (4) @(posedge aclk); keep_period <= 8'd0;
    wait_rst(1'b1, 300, n); span(n, 300, 300);
    watchdog_enable_fuse <= 1'b1;
    // Every prescale ratio, then an unassigned one with the largest selector
    for (int i = 0; i < 9; i++) begin
      ctrl = (i < 8) ? {28'h0, i[2:0], 1'b1} : 32'h0000_000E;
      wait_rst(1'b1, 5000, n);
      chk(32'(timeout_flag_n), 32'h0);
      repeat (2) @(posedge aclk); chk(32'(irq), 32'h1);
      axi_rd(STAT_OFF, rd, rs); chk(rd & 32'h31, 32'h21);
      axi_wr(CTRL_OFF, ctrl, rs);
      wait_rst(1'b0, 5000, n);
      wait_rst(1'b1, 5000, n); span(n, exp_wdt(ctrl) - 1, exp_wdt(ctrl) + 4);
    end
    // Delay length for each oscillator mode, in turn from a random starting mode
    lfsr = lfsr_step(lfsr); r = int'(lfsr % 6);
    wait_rst(1'b0, 5000, n);
    for (int m = 0; m < 6; m++) begin
      int mm;
      mm = (m + r) % 6;
      osc_mode <= mm[2:0];
      wait_rst(1'b1, 5000, n);
      wait_rst(1'b0, 5000, n); span(n, exp_drt(mm) - 1, exp_drt(mm) + 4);
    end
    // Watchdog resets of the mode loop left their event; read it clear first
    axi_rd(STAT_OFF, rd, rs); chk(rd & 32'h1, 32'h1);
    // Sleep at a random point after a clear: the full period must still run
    osc_mode <= 3'd0; keep_period <= 8'd15;
    lfsr = lfsr_step(lfsr);
    repeat (50 + lfsr % 15) @(posedge aclk);
    sleep_req <= 1'b1;
    @(posedge aclk); sleep_req <= 1'b0;
    n = 0;
    while (wake_reset !== 1'b1 && n < 5000) begin
      @(posedge aclk);
      n++;
    end
    span(n, WB - 1, WB + 4);
    @(posedge aclk); chk({wake_reset, core_reset}, 32'h1);
    wait_rst(1'b0, 5000, n); span(n, SHORT - 2, SHORT + 4);
    axi_rd(STAT_OFF, rd, rs); chk(rd & 32'h3, 32'h2);
    // Masked events must keep the interrupt low
    axi_wr(MASK_OFF, 32'h0, rs); keep_period <= 8'd0;
    wait_rst(1'b1, 5000, n); repeat (2) @(posedge aclk); chk(32'(irq), 32'h0);
    give_verdict;
  end
endmodule // test_watchdog_reset_delay_timer
